// ### hpc_port_config.sv
// hpc_port_config: configuration bank deciding numbering, strings, fixed and disabled ports
// assumes a single-cycle strobe master on clk; straps and supply pin are asynchronous pins
// Notes on behaviour
// - config byte three bit 3 chooses standard numbering or remap mode.
// - standard numbering shifts higher ports down past a disabled one.
// - remap mode takes port numbers from the remap register.
// - config byte three bit 0 turns string descriptors on.
// - fixed-device register bits 2 and 1 mark ports 2 and 1.
// - each active port reports whether its device is non-removable.
// - default configuration takes fixed-device marks from strap pins.
// - self-powered without remap, self port-off bits disable ports.
// - bus-powered without remap, bus port-off bits disable ports.
// - report correct enabled port count and reorder active ports.
// - port-off bits 2 and 1 disable ports 2 and 1; rest reserved.
// - default configuration takes port-off choice from strap pins.
// - with auto power switching, supply pin picks which port-off applies.
`timescale 1ns/10ps
module hpc_port_config (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic useDefaults,
  input wire logic autoPowerSwitch,
  input wire logic selfPowerBit,
  input wire logic local_supply_present,
  input wire logic [1:0] fixed_device_straps,
  input wire logic [1:0] port_off_straps,
  output logic stringEnable,
  output logic [1:0] portDisabled,
  output logic [1:0] portNonRemovable,
  output logic [1:0] hostNumPort1,
  output logic [1:0] hostNumPort2,
  output logic [1:0] enabledPortCount,
  output logic selfPowered
);
  logic [7:0] config_byte_three_reg;
  logic [7:0] config_byte_three_next;
  logic [7:0] fixed_reg;
  logic [7:0] fixed_next;
  logic [7:0] spOff_reg;
  logic [7:0] spOff_next;
  logic [7:0] bpOff_reg;
  logic [7:0] bpOff_next;
  logic [7:0] remap_reg;
  logic [7:0] remap_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // two-flop synchronisers for every pin input
  logic [5:0] pinMeta_reg;
  logic [5:0] pinSync_reg;
  wire [5:0] pinRaw;

  // registered outputs
  logic stringEn_reg;
  logic [1:0] disabled_reg;
  logic [1:0] fixedOut_reg;
  logic [1:0] num1_reg;
  logic [1:0] num2_reg;
  logic [1:0] count_reg;
  logic self_reg;

  hpc_map_if mapIf ();

  // write select shared by all register writes
  function automatic logic hitWrite(input logic wr, input logic [7:0] a,
                                    input logic [7:0] target);
    hitWrite = wr && (a == target);
  endfunction : hitWrite

  // pin synchroniser: first stage is read only by the second
  assign pinRaw = {useDefaults, local_supply_present, fixed_device_straps, port_off_straps};

  always_ff @(posedge clk) begin
    if (srst) begin
      pinMeta_reg <= 6'h00;
      pinSync_reg <= 6'h00;
    end else begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
    end
  end

  wire [1:0] syncPortOff;
  wire [1:0] syncFixed;
  wire syncSupply;
  wire syncDefaults;
  assign syncPortOff = pinSync_reg[1:0];
  assign syncFixed = pinSync_reg[3:2];
  assign syncSupply = pinSync_reg[4];
  assign syncDefaults = pinSync_reg[5];

  // register writes: reserved bits never stored, so they read as zero
  assign config_byte_three_next = hitWrite(regWr, regAddr, hpc_pkg::ADDR_CONFIG_BYTE_THREE)
                   ? (regWdata & hpc_pkg::CONFIG_BYTE_THREE_MASK) : config_byte_three_reg;
  assign fixed_next = hitWrite(regWr, regAddr, hpc_pkg::ADDR_FIXED)
                    ? (regWdata & hpc_pkg::PORT_MASK) : fixed_reg;
  assign spOff_next = hitWrite(regWr, regAddr, hpc_pkg::ADDR_SP_OFF)
                    ? (regWdata & hpc_pkg::PORT_MASK) : spOff_reg;
  assign bpOff_next = hitWrite(regWr, regAddr, hpc_pkg::ADDR_BP_OFF)
                    ? (regWdata & hpc_pkg::PORT_MASK) : bpOff_reg;
  assign remap_next = hitWrite(regWr, regAddr, hpc_pkg::ADDR_REMAP)
                    ? (regWdata & hpc_pkg::REMAP_MASK) : remap_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      config_byte_three_reg <= hpc_pkg::CONFIG_BYTE_THREE_RESET;
      fixed_reg <= hpc_pkg::PORT_RESET;
      spOff_reg <= hpc_pkg::PORT_RESET;
      bpOff_reg <= hpc_pkg::PORT_RESET;
      remap_reg <= hpc_pkg::REMAP_RESET;
    end else begin
      config_byte_three_reg <= config_byte_three_next;
      fixed_reg <= fixed_next;
      spOff_reg <= spOff_next;
      bpOff_reg <= bpOff_next;
      remap_reg <= remap_next;
    end
  end

  // source of port options: straps override registers under defaults
  hpc_pkg::hpc_src_t optSrc;
  assign optSrc = syncDefaults ? hpc_pkg::HPC_SRC_STRAPS : hpc_pkg::HPC_SRC_REGS;

  wire remapOn;
  wire selfNow;
  wire [1:0] regOffSel;
  wire [1:0] offChoice;
  wire [1:0] fixedChoice;
  wire [1:0] portOffNow;

  assign remapOn = config_byte_three_reg[hpc_pkg::CONFIG_BYTE_THREE_REMAP_BIT];
  // auto switching follows the supply pin, otherwise the software power bit
  assign selfNow = autoPowerSwitch ? syncSupply : selfPowerBit;
  assign regOffSel = selfNow ? spOff_reg[hpc_pkg::PORT_LSB +: 2]
                             : bpOff_reg[hpc_pkg::PORT_LSB +: 2];
  assign offChoice = (optSrc == hpc_pkg::HPC_SRC_STRAPS) ? syncPortOff : regOffSel;
  assign fixedChoice = (optSrc == hpc_pkg::HPC_SRC_STRAPS) ? syncFixed
                     : fixed_reg[hpc_pkg::PORT_LSB +: 2];
  // remap mode ignores port-off selections; the remap word decides
  assign portOffNow = remapOn ? 2'h0 : offChoice;

  assign mapIf.remapSel = remapOn;
  assign mapIf.portOff = portOffNow;
  assign mapIf.remapWord = {remap_reg[hpc_pkg::REMAP_P2_LSB +: 2], remap_reg[1:0]};

  hpc_port_numbering numbering (
    .mapIf(mapIf)
  );

  // port is disabled when no host number was given to it
  wire [1:0] hiddenNow;
  assign hiddenNow = {mapIf.numP2 == hpc_pkg::MAP_OFF, mapIf.numP1 == hpc_pkg::MAP_OFF};

  // outputs registered so the host side sees stable levels
  always_ff @(posedge clk) begin
    if (srst) begin
      stringEn_reg <= 1'b0;
      disabled_reg <= 2'h0;
      fixedOut_reg <= 2'h0;
      num1_reg <= 2'h0;
      num2_reg <= 2'h0;
      count_reg <= 2'h0;
      self_reg <= 1'b0;
    end else begin
      stringEn_reg <= config_byte_three_reg[hpc_pkg::CONFIG_BYTE_THREE_STRING_BIT];
      disabled_reg <= hiddenNow;
      fixedOut_reg <= fixedChoice & ~hiddenNow;
      num1_reg <= mapIf.numP1;
      num2_reg <= mapIf.numP2;
      count_reg <= mapIf.portCount;
      self_reg <= selfNow;
    end
  end

  assign stringEnable = stringEn_reg;
  assign portDisabled = disabled_reg;
  assign portNonRemovable = fixedOut_reg;
  assign hostNumPort1 = num1_reg;
  assign hostNumPort2 = num2_reg;
  assign enabledPortCount = count_reg;
  assign selfPowered = self_reg;

  // read mux: unmapped addresses read zero
  wire [7:0] statusWord;
  wire [7:0] mapWord;
  assign statusWord = {1'b0, remapOn, syncDefaults, selfNow, 2'h0, mapIf.portCount};
  assign mapWord = {2'h0, mapIf.numP2, 2'h0, mapIf.numP1};

  always_comb begin
    case (regAddr)
      hpc_pkg::ADDR_CONFIG_BYTE_THREE: rdata_next = config_byte_three_reg;
      hpc_pkg::ADDR_FIXED: rdata_next = fixed_reg;
      hpc_pkg::ADDR_SP_OFF: rdata_next = spOff_reg;
      hpc_pkg::ADDR_BP_OFF: rdata_next = bpOff_reg;
      hpc_pkg::ADDR_REMAP: rdata_next = remap_reg;
      hpc_pkg::ADDR_STATUS: rdata_next = statusWord;
      hpc_pkg::ADDR_MAPOUT: rdata_next = mapWord;
      default: rdata_next = hpc_pkg::READ_ZERO;
    endcase
    if (!regRd) begin
      rdata_next = hpc_pkg::READ_ZERO;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= hpc_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;
endmodule : hpc_port_config

// ### hpc_pkg.sv
// hpc_pkg: register map, field positions and reset values of the hub port configuration bank
// assumes byte-wide registers on a plain strobe port, two downstream ports
package hpc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NPORT = 2;
  localparam int MAP_W = 2;

  // register offsets
  localparam logic [7:0] ADDR_CONFIG_BYTE_THREE = 8'h08;
  localparam logic [7:0] ADDR_FIXED = 8'h09;
  localparam logic [7:0] ADDR_SP_OFF = 8'h0a;
  localparam logic [7:0] ADDR_BP_OFF = 8'h0b;
  localparam logic [7:0] ADDR_REMAP = 8'hfb;
  localparam logic [7:0] ADDR_STATUS = 8'he0;
  localparam logic [7:0] ADDR_MAPOUT = 8'he1;

  // field positions
  localparam int CONFIG_BYTE_THREE_STRING_BIT = 0;
  localparam int CONFIG_BYTE_THREE_REMAP_BIT = 3;
  localparam int PORT_LSB = 1;
  localparam int REMAP_P2_LSB = 4;
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_SELF_BIT = 4;
  localparam int STAT_STRAP_BIT = 5;
  localparam int STAT_REMAP_BIT = 6;
  localparam int MAPOUT_P2_LSB = 4;

  // writable masks and reset values
  localparam logic [7:0] CONFIG_BYTE_THREE_MASK = 8'h09;
  localparam logic [7:0] PORT_MASK = 8'h06;
  localparam logic [7:0] REMAP_MASK = 8'h33;
  localparam logic [7:0] CONFIG_BYTE_THREE_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] REMAP_RESET = 8'h21;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [1:0] MAP_OFF = 2'h0;

  // where the port options come from
  typedef enum logic [0:0] {
    HPC_SRC_REGS = 1'b0,
    HPC_SRC_STRAPS = 1'b1
  } hpc_src_t;
endpackage : hpc_pkg

// ### hpc_map_if.sv
// hpc_map_if: carries port enables and remap choice into the numbering module
// assumes one clock domain; purely combinational signals
`timescale 1ns/10ps
interface hpc_map_if;
  logic remapSel;
  logic [1:0] portOff;
  logic [3:0] remapWord;
  logic [1:0] numP1;
  logic [1:0] numP2;
  logic [1:0] portCount;

  modport cfg (output remapSel, output portOff, output remapWord,
               input numP1, input numP2, input portCount);
  modport num (input remapSel, input portOff, input remapWord,
               output numP1, output numP2, output portCount);
endinterface : hpc_map_if

// ### hpc_port_numbering.sv
// hpc_port_numbering: works out which number each physical port shows to the host
// assumes portOff already chosen by power mode and masked; 1 means port hidden
`timescale 1ns/10ps
module hpc_port_numbering (
  hpc_map_if.num mapIf
);
  wire p1On;
  wire p2On;
  wire [1:0] stdP1;
  wire [1:0] stdP2;

  // standard numbering: a hidden port shifts the next one down
  assign p1On = ~mapIf.portOff[0];
  assign p2On = ~mapIf.portOff[1];
  assign stdP1 = p1On ? 2'h1 : hpc_pkg::MAP_OFF;
  assign stdP2 = !p2On ? hpc_pkg::MAP_OFF : (p1On ? 2'h2 : 2'h1);

  // remap word takes over the numbering entirely
  assign mapIf.numP1 = mapIf.remapSel ? mapIf.remapWord[1:0] : stdP1;
  assign mapIf.numP2 = mapIf.remapSel ? mapIf.remapWord[3:2] : stdP2;

  // count of ports the host may enumerate; ports left without a number are not counted
  assign mapIf.portCount = {1'b0, mapIf.numP1 != hpc_pkg::MAP_OFF}
                         + {1'b0, mapIf.numP2 != hpc_pkg::MAP_OFF};
endmodule : hpc_port_numbering

// ### hpc_port_config_assertions.sv
// hpc_port_config_assertions: port-level checks of the port configuration bank
// assumes single-cycle strobes and strobes held low while srst is high
`timescale 1ns/10ps
module hpc_port_config_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic autoPowerSwitch,
  input wire logic selfPowerBit,
  input wire logic stringEnable,
  input wire logic [1:0] portDisabled,
  input wire logic [1:0] portNonRemovable,
  input wire logic [1:0] hostNumPort1,
  input wire logic [1:0] hostNumPort2,
  input wire logic [1:0] enabledPortCount,
  input wire logic selfPowered
);
  logic remapQ;
  logic [7:0] mapQ;
  logic [2:0] quiet;
  // shadow of the mode; the quiet count hides the two-cycle write latency
  always_ff @(posedge clk) begin
    if (srst) begin
      remapQ <= 1'b0;
      mapQ <= hpc_pkg::REMAP_RESET;
      quiet <= 3'h0;
    end else begin
      if (regWr && regAddr == hpc_pkg::ADDR_CONFIG_BYTE_THREE) remapQ <= regWdata[3];
      if (regWr && regAddr == hpc_pkg::ADDR_REMAP) mapQ <= regWdata;
      quiet <= regWr ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reserved_read_zero_a: assert property ($past(regRd) && $past(regAddr) == 8'h09
    |-> (regRdata & 8'hf9) == 8'h00) else $error("reserved bits read nonzero");
  string_follow_a: assert property ((regWr && regAddr == 8'h08) ##1 !regWr
    |=> stringEnable == $past(regWdata[0], 2)) else $error("string enable wrong");
  standard_shift_a: assert property (!remapQ && quiet >= 3'h3 && portDisabled == 2'h1
    |-> hostNumPort2 == 2'h1) else $error("port two not shifted down");
  standard_plain_a: assert property (!remapQ && quiet >= 3'h3 && portDisabled == 2'h0
    |-> hostNumPort1 == 2'h1 && hostNumPort2 == 2'h2) else $error("standard numbers wrong");
  remap_numbers_a: assert property (remapQ && quiet >= 3'h3
    |-> hostNumPort1 == mapQ[1:0] && hostNumPort2 == mapQ[5:4]) else $error("remap wrong");
  port_count_a: assert property (enabledPortCount == ({1'b0, hostNumPort1 != 2'h0}
    + {1'b0, hostNumPort2 != 2'h0})) else $error("enabled count wrong");
  hidden_unnumbered_a: assert property (!$past(srst)
    |-> portDisabled == {hostNumPort2 == 2'h0, hostNumPort1 == 2'h0}) else $error("hide wrong");
  fixed_active_a: assert property ((portNonRemovable & portDisabled) == 2'h0)
    else $error("fixed mark on disabled port");
  power_mode_a: assert property (!$past(srst) && !$past(autoPowerSwitch)
    && $stable(autoPowerSwitch) && $stable(selfPowerBit) |-> selfPowered == selfPowerBit)
    else $error("power mode wrong");
endmodule : hpc_port_config_assertions
bind hpc_port_config hpc_port_config_assertions i_chk (.clk(clk), .srst(srst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .autoPowerSwitch(autoPowerSwitch), .selfPowerBit(selfPowerBit), .stringEnable(stringEnable),
  .portDisabled(portDisabled), .portNonRemovable(portNonRemovable), .hostNumPort1(hostNumPort1),
  .hostNumPort2(hostNumPort2), .enabledPortCount(enabledPortCount), .selfPowered(selfPowered));

// ### hpc_host_model.sv
// hpc_host_model: upstream host that enumerates every port shown with a number
// assumes the hub numbers settle before the host looks at them
`timescale 1ns/10ps
module hpc_host_model (
  input wire logic clk,
  input wire logic [1:0] hostNumPort1,
  input wire logic [1:0] hostNumPort2,
  output logic [1:0] enumCount
);
  // a port numbered 0 cannot be enumerated by the host
  always_ff @(posedge clk) begin
    enumCount <= {1'b0, hostNumPort1 != 2'h0} + {1'b0, hostNumPort2 != 2'h0};
  end
endmodule : hpc_host_model

// ### tb_top.sv
// tb_top: random and corner-case test of the port configuration bank
// assumes the strobe register port and two-flop pin synchronisers
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic useDefaults = 1'b0;
  logic autoPowerSwitch = 1'b0;
  logic selfPowerBit = 1'b0;
  logic localSupply = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [1:0] fixStr = 2'h0;
  logic [1:0] offStr = 2'h0;
  logic [7:0] regRdata;
  logic stringEnable, selfPowered;
  logic [1:0] portDisabled, portNonRemovable, hostNumPort1, hostNumPort2, enabledPortCount;
  logic [1:0] enumCount;
  logic [7:0] cfg, fixed_device_ports, sp, bp, map;
  logic [7:0] adr [5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'hfb};
  logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h21};
  logic [7:0] msk [5] = '{8'h09, 8'h06, 8'h06, 8'h06, 8'h33};
  logic [7:0] maps [4] = '{8'h21, 8'h12, 8'h01, 8'h10};
  int err_count = 0;
  int n_checks = 0;
  int seed = 11463;
  always #50 clk = ~clk;
  hpc_port_config i_dut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .useDefaults(useDefaults),
    .autoPowerSwitch(autoPowerSwitch), .selfPowerBit(selfPowerBit),
    .local_supply_present(localSupply), .fixed_device_straps(fixStr),
    .port_off_straps(offStr), .stringEnable(stringEnable), .portDisabled(portDisabled),
    .portNonRemovable(portNonRemovable), .hostNumPort1(hostNumPort1),
    .hostNumPort2(hostNumPort2), .enabledPortCount(enabledPortCount), .selfPowered(selfPowered));
  hpc_host_model i_host (.clk(clk), .hostNumPort1(hostNumPort1), .hostNumPort2(hostNumPort2),
    .enumCount(enumCount));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask : rd
  function automatic logic [7:0] exp_map(input logic rm, input logic [1:0] off);
    logic [1:0] n1, n2;
    n1 = off[0] ? 2'h0 : 2'h1;
    n2 = off[1] ? 2'h0 : (off[0] ? 2'h1 : 2'h2);
    return rm ? (map & 8'h33) : {2'h0, n2, 2'h0, n1};
  endfunction : exp_map
  // six cycles cover two sync flops, the register and the output stage
  task automatic verify();
    logic self;
    logic [1:0] off, dis, cnt;
    logic [7:0] e, v;
    self = autoPowerSwitch ? localSupply : selfPowerBit;
    off = useDefaults ? offStr : (self ? sp[2:1] : bp[2:1]);
    e = exp_map(cfg[3], off);
    dis = {e[5:4] == 2'h0, e[1:0] == 2'h0};
    cnt = {1'b0, !dis[0]} + {1'b0, !dis[1]};
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("selfPowered", {7'h0, selfPowered}, {7'h0, self});
    check("portNumbers", {2'h0, hostNumPort2, 2'h0, hostNumPort1}, e);
    check("portDisabled", {6'h0, portDisabled}, {6'h0, dis});
    check("nonRemovable", {6'h0, portNonRemovable},
      {6'h0, (useDefaults ? fixStr : fixed_device_ports[2:1]) & ~dis});
    check("portCount", {6'h0, enabledPortCount}, {7'h0, !dis[0]} + {7'h0, !dis[1]});
    check("hostCount", {6'h0, enumCount}, {7'h0, !dis[0]} + {7'h0, !dis[1]});
    check("stringEnable", {7'h0, stringEnable}, {7'h0, cfg[0]});
    rd(8'he1, v);
    check("mapStatus", v, e);
    // read data must fall back to zero once its single cycle is over
    @(negedge clk);
    check("readIdle", regRdata, 8'h00);
    rd(8'he0, v);
    check("statusWord", v, {1'b0, cfg[3], useDefaults, self, 2'h0, cnt});
  endtask : verify
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    logic [7:0] v;
    logic [31:0] r;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // reset values, then which bits hold a write
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], v);
      check("resetValue", v, rst[i]);
      wr(adr[i], 8'hff);
      rd(adr[i], v);
      check("writableBits", v, msk[i]);
    end
    wr(8'h0c, 8'hff);
    rd(8'h0c, v);
    check("unmapped", v, 8'h00);
    $display("test registers done");
    // first three passes are hand-picked: port 1 off, port 2 off, reserved bit only
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      @(posedge clk);
      useDefaults <= (i > 2) & r[0];
      autoPowerSwitch <= (i > 2) & r[1];
      selfPowerBit <= (i > 2) ? r[2] : 1'b1;
      localSupply <= r[3];
      fixStr <= r[5:4];
      offStr <= r[7:6];
      cfg = (i > 2) ? r[15:8] : 8'h00;
      fixed_device_ports = r[23:16];
      sp = (i > 2) ? r[31:24] : (8'h02 << i);
      bp = $random(seed);
      map = maps[r[9:8]];
      wr(8'h08, cfg);
      wr(8'h09, fixed_device_ports);
      wr(8'h0a, sp);
      wr(8'h0b, bp);
      wr(8'hfb, map | 8'hcc);
      verify();
    end
    $display("test random done");
    wrap_up();
  end
  // the run needs about 920 cycles; this bound only catches a hang
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end
endmodule : tb_top
